// ---- cfg_pins_defines.svh ----
// Shared constants for the configuration status pins and test access port.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef CFG_PINS_DEFINES_SVH
`define CFG_PINS_DEFINES_SVH

`define CJ_NUM_IO 8
`define CJ_NUM_SYNC 4
`define CJ_PIN_RESTART 0
`define CJ_PIN_GOE 1
`define CJ_PIN_GCLR 2
`define CJ_PIN_STATUS 3
`define CJ_SYNC_RST 4'h0
`define CJ_STATUS_W 2
`define CJ_STAT_USER 0
`define CJ_STAT_LOW 1
`define CJ_SHIFT_W 8
`define CJ_SHIFT_MSB 7
`define CJ_SHIFT_PAD 6'h00

`endif

// ---- cfg_pins_pkg.sv ----
// Types shared by the configuration pin logic and the test access port.
// Assumes cfg_pins_defines.svh is on the include path.
`include "cfg_pins_defines.svh"

package cfg_pins_pkg;

    typedef enum logic [3:0] {
        CS_RESTART = 4'h1,
        CS_HEADER = 4'h2,
        CS_INIT = 4'h4,
        CS_USER = 4'h8
    } cfg_state_t;

    typedef enum logic [15:0] {
        TS_RESET = 16'h0001, TS_IDLE = 16'h0002,
        TS_SEL_DR = 16'h0004, TS_CAP_DR = 16'h0008,
        TS_SHIFT_DR = 16'h0010, TS_EXIT1_DR = 16'h0020,
        TS_PAUSE_DR = 16'h0040, TS_EXIT2_DR = 16'h0080,
        TS_UPD_DR = 16'h0100, TS_SEL_IR = 16'h0200,
        TS_CAP_IR = 16'h0400, TS_SHIFT_IR = 16'h0800,
        TS_EXIT1_IR = 16'h1000, TS_PAUSE_IR = 16'h2000,
        TS_EXIT2_IR = 16'h4000, TS_UPD_IR = 16'h8000
    } tap_state_t;

endpackage

// ---- core_status_if.sv ----
// Carrier for status bits passed from the core clock domain to the test port.
// Assumes the receiving side resynchronises every bit to its own clock.
`timescale 1ns/1ns
`include "cfg_pins_defines.svh"

interface core_status_if;
    logic [`CJ_STATUS_W-1:0] status;

    modport core (output status);
    modport tap (input status);
endinterface

// ---- test_port.sv ----
// Test access port: state machine, shift register and three-state serial output.
// Assumes TCK is a free clock from the tester and TRST_N may be tied low when unused.
`timescale 1ns/1ns
`include "cfg_pins_defines.svh"

module test_port
    import cfg_pins_pkg::*;
(
    input wire logic tck_in,
    input wire logic trst_n_in,
    input wire logic tms_in,
    input wire logic tdi_in,
    core_status_if.tap st,
    output logic tdo_out,
    output logic tdo_oe_out
);
    import cfg_pins_pkg::*;

    // -------------------------------------------------------------
    // Status crossing into the test clock domain
    // -------------------------------------------------------------
    logic [`CJ_STATUS_W-1:0] s1_ff, s2_ff, s3_ff, stat_ff, nxt_stat;

    always_comb begin
        nxt_stat = stat_ff;
        if (s2_ff == s3_ff) begin
            nxt_stat = s3_ff;
        end
    end

    always_ff @(posedge tck_in or negedge trst_n_in) begin
        if (!trst_n_in) begin
            s1_ff <= '0;
            s2_ff <= '0;
            s3_ff <= '0;
            stat_ff <= '0;
        end else begin
            s1_ff <= st.status;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            stat_ff <= nxt_stat;
        end
    end

    // -------------------------------------------------------------
    // Controller and shift register
    // -------------------------------------------------------------
    tap_state_t state_ff, nxt_state;
    logic [`CJ_SHIFT_W-1:0] sr_ff, nxt_sr;
    logic shifting;

    assign shifting = (state_ff == TS_SHIFT_DR) || (state_ff == TS_SHIFT_IR);

    always_comb begin
        nxt_sr = sr_ff;
        case (state_ff)
            TS_RESET: nxt_state = tms_in ? TS_RESET : TS_IDLE; // [RL14]
            TS_IDLE: nxt_state = tms_in ? TS_SEL_DR : TS_IDLE;
            TS_SEL_DR: nxt_state = tms_in ? TS_SEL_IR : TS_CAP_DR;
            TS_CAP_DR: nxt_state = tms_in ? TS_EXIT1_DR : TS_SHIFT_DR;
            TS_SHIFT_DR: nxt_state = tms_in ? TS_EXIT1_DR : TS_SHIFT_DR;
            TS_EXIT1_DR: nxt_state = tms_in ? TS_UPD_DR : TS_PAUSE_DR;
            TS_PAUSE_DR: nxt_state = tms_in ? TS_EXIT2_DR : TS_PAUSE_DR;
            TS_EXIT2_DR: nxt_state = tms_in ? TS_UPD_DR : TS_SHIFT_DR;
            TS_UPD_DR: nxt_state = tms_in ? TS_SEL_DR : TS_IDLE;
            TS_SEL_IR: nxt_state = tms_in ? TS_RESET : TS_CAP_IR;
            TS_CAP_IR: nxt_state = tms_in ? TS_EXIT1_IR : TS_SHIFT_IR;
            TS_SHIFT_IR: nxt_state = tms_in ? TS_EXIT1_IR : TS_SHIFT_IR;
            TS_EXIT1_IR: nxt_state = tms_in ? TS_UPD_IR : TS_PAUSE_IR;
            TS_PAUSE_IR: nxt_state = tms_in ? TS_EXIT2_IR : TS_PAUSE_IR;
            TS_EXIT2_IR: nxt_state = tms_in ? TS_UPD_IR : TS_SHIFT_IR;
            TS_UPD_IR: nxt_state = tms_in ? TS_SEL_DR : TS_IDLE;
            default: nxt_state = TS_RESET;
        endcase
        if ((state_ff == TS_CAP_DR) || (state_ff == TS_CAP_IR)) begin
            nxt_sr = {`CJ_SHIFT_PAD, stat_ff};
        end else if (shifting) begin
            nxt_sr = {tdi_in, sr_ff[`CJ_SHIFT_MSB:1]}; // [RL11]
        end
    end

    // A low TRST_N clears the port at once; tied low when unused, it holds the port in TS_RESET.
    always_ff @(posedge tck_in or negedge trst_n_in) begin
        if (!trst_n_in) begin
            state_ff <= TS_RESET; // [RL15] [RL16]
            sr_ff <= '0;
        end else begin
            state_ff <= nxt_state;
            sr_ff <= nxt_sr;
        end
    end

    // -------------------------------------------------------------
    // Serial output on the falling edge
    // -------------------------------------------------------------
    logic nxt_tdo, nxt_tdo_oe;

    always_comb begin
        nxt_tdo = sr_ff[0];
        nxt_tdo_oe = shifting; // [RL13]
    end

    always_ff @(negedge tck_in or negedge trst_n_in) begin
        if (!trst_n_in) begin
            tdo_out <= 1'b0;
            tdo_oe_out <= 1'b0;
        end else begin
            tdo_out <= nxt_tdo; // [RL12]
            tdo_oe_out <= nxt_tdo_oe;
        end
    end

    a_tdi_shift_in: assert property (@(posedge tck_in) disable iff (!trst_n_in) // [RL11]
        shifting |=> sr_ff[`CJ_SHIFT_MSB] == $past(tdi_in))
        else $error("TDI bit not shifted in on the rising edge.");
    a_tms_advance: assert property (@(posedge tck_in) disable iff (!trst_n_in) // [RL14]
        (state_ff == TS_SHIFT_DR) && tms_in |=> state_ff == TS_EXIT1_DR)
        else $error("Controller did not follow the sampled mode select.");
    a_tdo_idle_float: assert property (@(posedge tck_in) disable iff (!trst_n_in) // [RL13]
        (state_ff == TS_IDLE) && $past(state_ff == TS_IDLE) |-> !tdo_oe_out)
        else $error("Serial output driven while not shifting.");
    a_tdo_fall_update: assert property (@(negedge tck_in) disable iff (!trst_n_in) // [RL12]
        $past(shifting) && shifting |-> ##1 tdo_oe_out)
        else $error("Serial output not enabled during a shift.");
    a_trst_reset_now: assert property (@(posedge tck_in) disable iff (1'b0) // [RL15]
        !trst_n_in |-> state_ff == TS_RESET && !tdo_oe_out)
        else $error("Test reset did not act immediately.");

endmodule // test_port

// ---- cfg_jtag_pins.sv ----
// Configuration status pin, device-wide output enable and clear, and test port.
// Assumes the configuration engine on CLK_IN reports the first frame and the end of
// initialization, and that the test pins belong to the TCK domain.
`timescale 1ns/1ns
`include "cfg_pins_defines.svh"

// How it works
// RL1 - While restart is low or configuration starts, leave the status pin undriven.
// RL2 - After the first frame loads the status option, drive the status pin low.
// RL3 - When initialization finishes, release the status pin and enter user mode.
// RL4 - The monitor must look for a rising edge on the status pin.
// RL5 - Status, output enable and clear pins act only with their option set.
// RL6 - A low global output enable forces every user pin to high impedance; only IO_OE_OUT is forced, not the status pin as a user pin.
// RL7 - A high global output enable lets user pins follow their own enables.
// RL8 - A low global clear clears every user register regardless of its controls.
// RL9 - A high global clear lets user registers follow their own clear.
// RL10 - The tester keeps test pins stable before and during configuration.
// RL11 - Serial test input is sampled on each rising test clock edge.
// RL12 - Serial test output changes on each falling test clock edge while shifting.
// RL13 - Serial test output floats whenever nothing is being shifted out.
// RL14 - The test controller moves on rising edges using the sampled mode select.
// RL15 - A low test reset clears the test circuitry at once, without a clock.
// RL16 - An unused test port is tied off so the test circuitry stays disabled.
// RL17 - Global enable and clear act asynchronously, as levels, while held low.
module cfg_jtag_pins
    import cfg_pins_pkg::*;
(
    input wire logic CLK_IN,
    input wire logic ARST_N_IN,
    input wire logic CONFIG_RESTART_N_IN,
    input wire logic CFG_FRAME0_LOADED_IN,
    input wire logic CFG_INIT_COMPLETE_IN,
    input wire logic CFG_OPT_STATUS_IN,
    input wire logic CFG_OPT_GOE_IN,
    input wire logic CFG_OPT_GCLR_IN,
    input wire logic INIT_DONE_IN,
    input wire logic USER_STATUS_PIN_IN,
    input wire logic USER_STATUS_PIN_OE_IN,
    input wire logic GLOBAL_OUTPUT_ENABLE_IN,
    input wire logic GLOBAL_REGISTER_CLEAR_N_IN,
    input wire logic [`CJ_NUM_IO-1:0] USER_IO_IN,
    input wire logic [`CJ_NUM_IO-1:0] USER_IO_OE_IN,
    input wire logic [`CJ_NUM_IO-1:0] USER_REG_D_IN,
    input wire logic [`CJ_NUM_IO-1:0] USER_REG_CLR_IN,
    input wire logic TCK_IN,
    input wire logic TRST_N_IN,
    input wire logic TMS_IN,
    input wire logic TDI_IN,
    output logic INIT_DONE_OUT,
    output logic INIT_DONE_OE_OUT,
    output logic USER_MODE_OUT,
    output logic [2:0] USER_PIN_LEVEL_OUT,
    output logic [`CJ_NUM_IO-1:0] IO_OUT,
    output logic [`CJ_NUM_IO-1:0] IO_OE_OUT,
    output logic [`CJ_NUM_IO-1:0] USER_REG_OUT,
    output logic TDO_OUT,
    output logic TDO_OE_OUT
);
    import cfg_pins_pkg::*;

    // -------------------------------------------------------------
    // Pin synchronisers
    // -------------------------------------------------------------
    // A level change counts only once the second and third stages agree, which
    // filters a single-cycle disagreement at the cost of one extra cycle.
    logic [`CJ_NUM_SYNC-1:0] pin_raw;
    logic [`CJ_NUM_SYNC-1:0] pin_s1_ff, pin_s2_ff, pin_s3_ff;
    logic [`CJ_NUM_SYNC-1:0] pin_stable_ff, nxt_pin_stable;

    assign pin_raw[`CJ_PIN_RESTART] = CONFIG_RESTART_N_IN;
    assign pin_raw[`CJ_PIN_GOE] = GLOBAL_OUTPUT_ENABLE_IN;
    assign pin_raw[`CJ_PIN_GCLR] = GLOBAL_REGISTER_CLEAR_N_IN;
    assign pin_raw[`CJ_PIN_STATUS] = INIT_DONE_IN;

    always_comb begin
        nxt_pin_stable = pin_stable_ff;
        for (int i = 0; i < `CJ_NUM_SYNC; i++) begin
            if (pin_s2_ff[i] == pin_s3_ff[i]) begin
                nxt_pin_stable[i] = pin_s3_ff[i];
            end
        end
    end

    always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            pin_s1_ff <= `CJ_SYNC_RST;
            pin_s2_ff <= `CJ_SYNC_RST;
            pin_s3_ff <= `CJ_SYNC_RST;
            pin_stable_ff <= `CJ_SYNC_RST;
        end else begin
            pin_s1_ff <= pin_raw;
            pin_s2_ff <= pin_s1_ff;
            pin_s3_ff <= pin_s2_ff;
            pin_stable_ff <= nxt_pin_stable;
        end
    end

    logic restart_released;

    assign restart_released = pin_stable_ff[`CJ_PIN_RESTART];

    // -------------------------------------------------------------
    // Configuration sequence and option bits
    // -------------------------------------------------------------
    cfg_state_t state_ff, nxt_state;
    logic opt_status_ff, opt_goe_ff, opt_gclr_ff;
    logic nxt_opt_status, nxt_opt_goe, nxt_opt_gclr;

    always_comb begin
        nxt_state = state_ff;
        nxt_opt_status = opt_status_ff;
        nxt_opt_goe = opt_goe_ff;
        nxt_opt_gclr = opt_gclr_ff;
        if (!restart_released) begin
            nxt_state = CS_RESTART;
            nxt_opt_status = 1'b0;
            nxt_opt_goe = 1'b0;
            nxt_opt_gclr = 1'b0;
        end else begin
            case (state_ff)
                CS_RESTART: begin
                    nxt_state = CS_HEADER;
                end
                CS_HEADER: begin
                    if (CFG_FRAME0_LOADED_IN) begin
                        nxt_state = CS_INIT;
                        nxt_opt_status = CFG_OPT_STATUS_IN;
                        nxt_opt_goe = CFG_OPT_GOE_IN;
                        nxt_opt_gclr = CFG_OPT_GCLR_IN;
                    end
                end
                CS_INIT: begin
                    if (CFG_INIT_COMPLETE_IN) begin
                        nxt_state = CS_USER; // [RL3]
                    end
                end
                CS_USER: begin
                    nxt_state = CS_USER;
                end
                default: begin
                    nxt_state = CS_RESTART;
                end
            endcase
        end
    end

    always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            state_ff <= CS_RESTART;
            opt_status_ff <= 1'b0;
            opt_goe_ff <= 1'b0;
            opt_gclr_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            opt_status_ff <= nxt_opt_status;
            opt_goe_ff <= nxt_opt_goe;
            opt_gclr_ff <= nxt_opt_gclr;
        end
    end

    // -------------------------------------------------------------
    // Status pin and user-mode flag
    // -------------------------------------------------------------
    // The pin is open drain: with the option set it only ever pulls low, and the
    // external pull-up supplies the high level, so a monitor sees a rising edge.
    logic nxt_init_done, nxt_init_done_oe, nxt_user_mode;
    logic [2:0] nxt_pin_level;

    always_comb begin
        nxt_user_mode = (nxt_state == CS_USER); // [RL3]
        if (nxt_opt_status) begin
            nxt_init_done = 1'b0;
            nxt_init_done_oe = (nxt_state == CS_INIT); // [RL1] [RL2] [RL3]
        end else begin
            // As a plain user pin it floats until user mode; the user I/O enables are not gated by the sequence.
            nxt_init_done = USER_STATUS_PIN_IN; // [RL5]
            nxt_init_done_oe = USER_STATUS_PIN_OE_IN & (nxt_state == CS_USER); // [RL1]
        end
        // Pins whose option is off read back to user logic as plain inputs.
        nxt_pin_level[0] = opt_status_ff ? 1'b0 : pin_stable_ff[`CJ_PIN_STATUS]; // [RL5]
        nxt_pin_level[1] = opt_goe_ff ? 1'b0 : pin_stable_ff[`CJ_PIN_GOE];
        nxt_pin_level[2] = opt_gclr_ff ? 1'b0 : pin_stable_ff[`CJ_PIN_GCLR];
    end

    always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            INIT_DONE_OUT <= 1'b0;
            INIT_DONE_OE_OUT <= 1'b0;
            USER_MODE_OUT <= 1'b0;
            USER_PIN_LEVEL_OUT <= '0;
        end else begin
            INIT_DONE_OUT <= nxt_init_done;
            INIT_DONE_OE_OUT <= nxt_init_done_oe;
            USER_MODE_OUT <= nxt_user_mode;
            USER_PIN_LEVEL_OUT <= nxt_pin_level;
        end
    end

    // -------------------------------------------------------------
    // Device-wide output enable and clear
    // -------------------------------------------------------------
    // Both overrides reach the flip-flops through their asynchronous clear so
    // they act at once and hold for as long as the pin is low. The option bits
    // only change during configuration, which keeps these gated resets glitch free
    // in user mode; a glitch on the raw pin will clear the affected bank.
    logic io_arst_n, reg_arst_n;

    assign io_arst_n = ARST_N_IN & ~(opt_goe_ff & ~GLOBAL_OUTPUT_ENABLE_IN); // [RL6] [RL17]
    assign reg_arst_n = ARST_N_IN & ~(opt_gclr_ff & ~GLOBAL_REGISTER_CLEAR_N_IN); // [RL8] [RL17]

    logic [`CJ_NUM_IO-1:0] nxt_io, nxt_io_oe, nxt_user_reg;

    always_comb begin
        nxt_io = USER_IO_IN;
        nxt_io_oe = USER_IO_OE_IN; // [RL7]
        nxt_user_reg = USER_REG_D_IN & ~USER_REG_CLR_IN; // [RL9]
    end

    always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            IO_OUT <= '0;
        end else begin
            IO_OUT <= nxt_io;
        end
    end

    always_ff @(posedge CLK_IN or negedge io_arst_n) begin
        if (!io_arst_n) begin
            IO_OE_OUT <= '0; // [RL6]
        end else begin
            IO_OE_OUT <= nxt_io_oe;
        end
    end

    always_ff @(posedge CLK_IN or negedge reg_arst_n) begin
        if (!reg_arst_n) begin
            USER_REG_OUT <= '0; // [RL8]
        end else begin
            USER_REG_OUT <= nxt_user_reg;
        end
    end

    // -------------------------------------------------------------
    // Test access port
    // -------------------------------------------------------------
    // Only slow configuration levels cross to the test clock; both bits are
    // resynchronised there together and taken only once the second and third
    // stages agree on the whole pair, so a one test clock skew is never captured.
    core_status_if u_status_if ();
    logic [`CJ_STATUS_W-1:0] nxt_status;
    logic [`CJ_STATUS_W-1:0] status_ff;

    always_comb begin
        nxt_status[`CJ_STAT_USER] = nxt_user_mode;
        nxt_status[`CJ_STAT_LOW] = nxt_init_done_oe & nxt_opt_status;
    end

    always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            status_ff <= '0;
        end else begin
            status_ff <= nxt_status;
        end
    end

    assign u_status_if.status = status_ff;

    test_port u_test_port (
        .tck_in(TCK_IN),
        .trst_n_in(TRST_N_IN),
        .tms_in(TMS_IN),
        .tdi_in(TDI_IN),
        .st(u_status_if.tap),
        .tdo_out(TDO_OUT),
        .tdo_oe_out(TDO_OE_OUT)
    );

    // -------------------------------------------------------------
    // Checks
    // -------------------------------------------------------------
    default clocking cb @(posedge CLK_IN);
    endclocking
    default disable iff (!ARST_N_IN);

    sequence seq_first_frame;
        (state_ff == CS_HEADER) && restart_released && CFG_FRAME0_LOADED_IN && CFG_OPT_STATUS_IN;
    endsequence

    sequence seq_init_finish;
        (state_ff == CS_INIT) && restart_released && CFG_INIT_COMPLETE_IN && opt_status_ff;
    endsequence

    a_restart_floats: assert property ( // [RL1]
        (state_ff == CS_RESTART || state_ff == CS_HEADER) |-> !INIT_DONE_OE_OUT)
        else $error("Status pin driven before the first frame.");
    a_frame_drives_low: assert property ( // [RL2]
        seq_first_frame |=> INIT_DONE_OE_OUT && !INIT_DONE_OUT ##1 INIT_DONE_OE_OUT || USER_MODE_OUT || !restart_released)
        else $error("Status pin not pulled low after the first frame.");
    a_init_release: assert property ( // [RL3]
        seq_init_finish |=> !INIT_DONE_OE_OUT && USER_MODE_OUT)
        else $error("Status pin not released on end of initialization.");
    a_option_off_user: assert property ( // [RL5]
        (state_ff == CS_USER) && restart_released && !opt_status_ff
        |=> INIT_DONE_OE_OUT == $past(USER_STATUS_PIN_OE_IN) && INIT_DONE_OUT == $past(USER_STATUS_PIN_IN))
        else $error("Status pin not acting as user pin with its option off.");
    a_goe_tristate: assert property ( // [RL6]
        opt_goe_ff && !GLOBAL_OUTPUT_ENABLE_IN |-> IO_OE_OUT == '0)
        else $error("User pins driven while global output enable is low.");
    a_goe_follows: assert property ( // [RL7]
        opt_goe_ff && GLOBAL_OUTPUT_ENABLE_IN ##1 GLOBAL_OUTPUT_ENABLE_IN |-> IO_OE_OUT == $past(USER_IO_OE_IN))
        else $error("User pin enables not followed while global enable is high.");
    a_gclr_clears: assert property ( // [RL8]
        opt_gclr_ff && !GLOBAL_REGISTER_CLEAR_N_IN |-> USER_REG_OUT == '0)
        else $error("User registers not cleared while global clear is low.");
    a_gclr_follows: assert property ( // [RL9]
        GLOBAL_REGISTER_CLEAR_N_IN ##1 GLOBAL_REGISTER_CLEAR_N_IN
        |-> USER_REG_OUT == ($past(USER_REG_D_IN) & ~$past(USER_REG_CLR_IN)))
        else $error("User registers not following their own clear.");
    a_restart_returns: assert property ( // [RL1]
        !restart_released |=> state_ff == CS_RESTART && !USER_MODE_OUT)
        else $error("Restart did not return the sequence to its start.");

    // Both options off for two edges, so no gated reset can have fired between them.
    sequence seq_override_off;
        !opt_goe_ff && !opt_gclr_ff ##1 !opt_goe_ff && !opt_gclr_ff;
    endsequence

    a_override_off: assert property ( // [RL5]
        seq_override_off |-> IO_OE_OUT == $past(USER_IO_OE_IN)
        && USER_REG_OUT == ($past(USER_REG_D_IN) & ~$past(USER_REG_CLR_IN)))
        else $error("Override pin acted with its option off.");
    a_level_masked: assert property ( // [RL5]
        opt_status_ff && opt_goe_ff && opt_gclr_ff |=> USER_PIN_LEVEL_OUT == '0)
        else $error("Dedicated pin read back as a user input.");
    a_status_low_init: assert property ( // [RL2]
        (state_ff == CS_INIT) && opt_status_ff |-> INIT_DONE_OE_OUT && !INIT_DONE_OUT)
        else $error("Status pin not low during initialization.");
    a_user_mode_level: assert property ( // [RL3]
        (state_ff == CS_USER) |-> USER_MODE_OUT)
        else $error("User mode flag low in user mode.");
    a_restart_clears_opts: assert property ( // [RL5]
        !restart_released |=> !opt_status_ff && !opt_goe_ff && !opt_gclr_ff)
        else $error("Restart left an option bit set.");

endmodule // cfg_jtag_pins

// ---- cfg_far_side.sv ----
// Board-side model: status pin monitor and boundary-scan tester.
// Assumes the bench calls tick once for each test clock cycle it needs.
`timescale 1ns/1ns
module cfg_far_side (
    output logic tck_out,
    output logic trst_n_out,
    output logic tms_out,
    output logic tdi_out,
    input wire logic tdo_in,
    input wire logic tdo_oe_in,
    input wire logic status_pin_in,
    output int rise_cnt_out
);
    // ------------------------------------------------------------
    // Test pins and status monitor
    // ------------------------------------------------------------
    // The test clock stands still between frames so nothing is loaded by accident.
    initial begin
        tck_out = 1'b0;
        tms_out = 1'b1;
        tdi_out = 1'b1;
        trst_n_out = 1'b1;
        rise_cnt_out = 0;
        // A real falling edge, so the port is reset even from time zero.
        #1 trst_n_out = 1'b0;
        #49 trst_n_out = 1'b1;
    end
    // A level alone could be the pull-up before configuration, so only edges count.
    always @(posedge status_pin_in) begin
        rise_cnt_out <= rise_cnt_out + 1;
    end
    task automatic set_trst(input logic v);
        trst_n_out = v;
    endtask
    task automatic tick(input logic m, input logic d, output logic o, output logic e);
        tms_out = m;
        tdi_out = d;
        #3;
        o = tdo_oe_in ? tdo_in : ~tdo_in;
        e = tdo_oe_in;
        tck_out = 1'b1;
        #3;
        tck_out = 1'b0;
    endtask
endmodule // cfg_far_side

// ---- test_cfg_jtag_pins.sv ----
// Self-checking bench for the configuration pins and the test port.
// Assumes cfg_far_side stands in for the board and makes the test clock.
`timescale 1ns/1ns
module test_cfg_jtag_pins;
    import cfg_pins_pkg::*;
    logic clk = 1'b0, arst_n = 1'b0, restart_n = 1'b0, frame0 = 1'b0, init_cmp = 1'b0;
    logic usr_st = 1'b1, usr_st_oe = 1'b0, goe = 1'b1, gclr_n = 1'b1, d, o, e;
    logic [2:0] opts = 3'h0;
    logic [7:0] uio = 8'h00, uoe = 8'h00, ud = 8'h00, uclr = 8'h00, exp2;
    logic done_o, done_oe, user_mode, tck, trst_n, tms, tdi, tdo, tdo_oe, pin;
    logic [2:0] lvl;
    logic [7:0] io_o, io_oe, ureg;
    int error_cnt = 0, cmp_count = 0, seed = 32'hCD61F51C, rises, r0, i;
    logic q[$];
    // ------------------------------------------------------------
    // Design, board model and helpers
    // ------------------------------------------------------------
    assign pin = done_oe ? done_o : 1'b1;
    cfg_jtag_pins i_cfg_jtag_pins (.CLK_IN(clk), .ARST_N_IN(arst_n), .CONFIG_RESTART_N_IN(restart_n),
        .CFG_FRAME0_LOADED_IN(frame0), .CFG_INIT_COMPLETE_IN(init_cmp), .CFG_OPT_STATUS_IN(opts[0]),
        .CFG_OPT_GOE_IN(opts[1]), .CFG_OPT_GCLR_IN(opts[2]), .INIT_DONE_IN(pin), .USER_STATUS_PIN_IN(usr_st),
        .USER_STATUS_PIN_OE_IN(usr_st_oe), .GLOBAL_OUTPUT_ENABLE_IN(goe), .GLOBAL_REGISTER_CLEAR_N_IN(gclr_n),
        .USER_IO_IN(uio), .USER_IO_OE_IN(uoe), .USER_REG_D_IN(ud), .USER_REG_CLR_IN(uclr), .TCK_IN(tck),
        .TRST_N_IN(trst_n), .TMS_IN(tms), .TDI_IN(tdi), .INIT_DONE_OUT(done_o), .INIT_DONE_OE_OUT(done_oe),
        .USER_MODE_OUT(user_mode), .USER_PIN_LEVEL_OUT(lvl), .IO_OUT(io_o), .IO_OE_OUT(io_oe),
        .USER_REG_OUT(ureg), .TDO_OUT(tdo), .TDO_OE_OUT(tdo_oe));
    cfg_far_side u_far (.tck_out(tck), .trst_n_out(trst_n), .tms_out(tms), .tdi_out(tdi), .tdo_in(tdo),
        .tdo_oe_in(tdo_oe), .status_pin_in(pin), .rise_cnt_out(rises));
    initial begin
        forever #10 clk = ~clk;
    end
    task automatic check(input logic [10:0] seen, input logic [10:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict;
        if (error_cnt == 0 && cmp_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask
    task automatic configure(input logic [2:0] op);
        step(6);
        init_cmp = 1'b1;
        step(1);
        init_cmp = 1'b0;
        check(user_mode, 1'b0);
        frame0 = 1'b1;
        opts = op;
        step(1);
        frame0 = 1'b0;
        check({done_oe, done_o & done_oe}, {op[0], 1'b0});
        step(3);
        r0 = rises;
        init_cmp = 1'b1;
        step(1);
        init_cmp = 1'b0;
        check({user_mode, done_oe}, {1'b1, ~op[0] & usr_st_oe});
        check(11'(rises - r0), op[0]);
    endtask
    // Shifts eight bits, LSB first out, and leaves the port parked in Pause-DR.
    task automatic scan8(input logic [7:0] exp);
        for (int k = 0; k < 8; k++) begin
            d = 1'($random(seed));
            q.push_back(d);
            u_far.tick(k == 7, d, o, e);
            check({e, o}, {1'b1, exp[k]});
        end
        u_far.tick(1'b0, 1'b1, o, e);
        check(e, 1'b0);
    endtask
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        #1000000;
        error_cnt++;
        print_verdict;
    end
    initial begin
        repeat (16) @(posedge clk);
        #2 arst_n = 1'b1;
        step(6);
        check(done_oe, 1'b0);
        restart_n = 1'b1;
        configure(3'h7);
        for (i = 0; i < 24; i++) begin
            {uio, uoe, ud, uclr} = $random(seed);
            {goe, gclr_n} = 2'($random(seed));
            #1;
            if (!goe) check(io_oe, 8'h00);
            if (!gclr_n) check(ureg, 8'h00);
            step(1);
            check(io_oe, goe ? uoe : 8'h00);
            check(ureg, gclr_n ? (ud & ~uclr) : 8'h00);
            check({lvl, io_o}, {3'h0, uio});
        end
        {restart_n, usr_st_oe} = 2'h1;
        step(6);
        check({user_mode, done_oe}, 2'h0);
        restart_n = 1'b1;
        configure(3'h0);
        for (i = 0; i < 4; i++) begin
            {goe, gclr_n, usr_st_oe, usr_st} = 4'($random(seed));
            uoe = 8'($random(seed));
            step(6);
            check({lvl, io_oe}, {gclr_n, goe, usr_st_oe ? usr_st : 1'b1, uoe});
            check({done_oe, done_o, ureg}, {usr_st_oe, usr_st, ud & ~uclr});
        end
        for (i = 0; i < 5; i++) u_far.tick(1'b0, 1'b1, o, e);
        u_far.tick(1'b1, 1'b1, o, e);
        u_far.tick(1'b0, 1'b1, o, e);
        u_far.tick(1'b0, 1'b1, o, e);
        scan8(8'h01);
        for (i = 0; i < 8; i++) exp2[i] = q.pop_front();
        u_far.tick(1'b1, 1'b1, o, e);
        u_far.tick(1'b0, 1'b1, o, e);
        scan8(exp2);
        u_far.tick(1'b1, 1'b1, o, e);
        u_far.tick(1'b0, 1'b1, o, e);
        u_far.tick(1'b0, 1'b1, o, e);
        check(e, 1'b1);
        u_far.set_trst(1'b0);
        #1;
        check(tdo_oe, 1'b0);
        u_far.tick(1'b0, 1'b0, o, e);
        check({e, tdo_oe}, 2'h0);
        u_far.set_trst(1'b1);
        print_verdict;
    end
endmodule // test_cfg_jtag_pins
